/* inc/fine_edge_defines.svh */
// Constants for the fine edge PWM extension
// Summary of operation
// - Combined 32-bit coarse plus fine period write only at the mirror address.
// - Fine placement acts on channel A path; B only through routing options.
// - Configuration register sits at offset 20h and holds all options.
// - Edge mode picks rising, falling or both edges for fine placement.
// - Control mode picks duty or phase extension as step source.
// - With period fine control, duty and phase extensions still apply.
// - Shadow mode double-buffers duty and period extensions only.
// - Phase extension ignores shadow mode, always applied directly.
// - Swap option puts the fine waveform on the B pin.
// - Invert option without swap drives B with complement of fine A waveform.
// - Auto-conversion scales duty fraction by calibrated steps per coarse.
// - Without auto-conversion duty extension is the step count directly.
// - Period extension auto-conversion scales the same as duty.
// - Delay line places edge at 8-bit step position in coarse clock.
// - Fine byte sits below its 16-bit coarse value in combined word.
// - Mirror address reads return undefined data, here zero.
// - Fine placement off first 3 cycles after period start unless period fine control is on; coarse runs.
// - Low byte of written extension word ignored; upper byte used.
`ifndef FINE_EDGE_DEFINES_SVH
`define FINE_EDGE_DEFINES_SVH
`define IDX_PHASE_EXT 6'h02
`define IDX_PERIOD_EXT 6'h06
`define IDX_DUTY_EXT 6'h08
`define IDX_CONFIG 6'h20
`define IDX_STEPS 6'h26
`define IDX_STATUS 6'h28
`define IDX_PERIOD_MIR 6'h2a
`define IDX_DUTY_MIR 6'h2c
`define IDX_PERIOD_CRS 6'h30
`define IDX_DUTY_CRS 6'h31
`define IDX_LSB 2
`define EXT_HI 15
`define EXT_LO 8
`define CRS_HI 31
`define CRS_LO 16
`define CFG_RESET 8'h00
`define STEPS_RESET 8'h00
`define BLANK_CYCLES 2'h3
`define ROUND_HALF 16'h0080
`endif

/* inc/fine_edge_pkg.sv */
// Types for the fine edge PWM extension
package fine_edge_pkg;
    typedef enum logic [1:0] {EM_OFF, EM_RISE, EM_FALL, EM_BOTH} edge_mode_t;
    typedef struct packed {
        logic prd_en;
        logic auto_conv;
        logic inv_b;
        logic swap;
        logic shadow_en;
        logic ctl_phase;
        edge_mode_t edge_mode;
    } cfg_t;
endpackage

/* core/fine_edge_pwm.sv */
// Fine edge placement extension for one PWM channel, APB slave
`timescale 1ns/1ns
`include "fine_edge_defines.svh"
module fine_edge_pwm #(
    parameter int AW = 8
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic TB_PRD_START,
    input wire logic PWM_A_RAW,
    input wire logic PWM_B_RAW,
    output logic PWM_OUT_A,
    output logic PWM_OUT_B,
    output logic [7:0] DELAY_TAP,
    output logic [15:0] PERIOD_COARSE,
    output logic [15:0] DUTY_COARSE
);

    // Fraction to steps: (ext * steps + half) >> 8, or ext as is
    function automatic logic [7:0] conv(
        input logic [7:0] ext,
        input logic [7:0] spc,
        input logic auto_on
    );
        logic [15:0] prod;
        prod = 16'(ext) * 16'(spc) + `ROUND_HALF;
        conv = auto_on ? prod[15:8] : ext;
    endfunction

    function automatic logic mapped(input logic [5:0] i);
        mapped = (i == `IDX_PHASE_EXT) || (i == `IDX_PERIOD_EXT) || (i == `IDX_DUTY_EXT)
            || (i == `IDX_CONFIG) || (i == `IDX_STEPS) || (i == `IDX_STATUS)
            || (i == `IDX_PERIOD_MIR) || (i == `IDX_DUTY_MIR)
            || (i == `IDX_PERIOD_CRS) || (i == `IDX_DUTY_CRS);
    endfunction

    fine_edge_pkg::cfg_t cfg_q;
    logic [7:0] steps_q;
    logic [7:0] phase_q;
    logic [7:0] duty_buf_q;
    logic [7:0] duty_act_q;
    logic [7:0] period_buf_q;
    logic [7:0] period_act_q;
    logic [15:0] period_crs_q;
    logic [15:0] duty_crs_q;
    logic [1:0] blank_cnt_q;
    logic a_q;
    logic out_a_q;
    logic out_b_q;
    logic [7:0] tap_q;
    logic [31:0] rdata_q;
    logic [5:0] idx;
    logic wr;
    logic rd_setup;
    logic blank;
    logic rise;
    logic fall;
    logic sel_edge;
    logic [7:0] steps_now;

    assign idx = PADDR[`IDX_LSB +: 6];
    assign wr = PSEL & PENABLE & PWRITE;
    assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
    // Zero wait states keeps the compare path simple
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped(idx);
    assign PRDATA = rdata_q;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            cfg_q <= fine_edge_pkg::cfg_t'(`CFG_RESET);
        else if (wr && idx == `IDX_CONFIG)
            cfg_q <= fine_edge_pkg::cfg_t'(PWDATA[7:0]);
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            steps_q <= `STEPS_RESET;
        else if (wr && idx == `IDX_STEPS)
            steps_q <= PWDATA[7:0];
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            phase_q <= 8'h00;
        else if (wr && idx == `IDX_PHASE_EXT)
            phase_q <= PWDATA[`EXT_HI:`EXT_LO];
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            duty_buf_q <= 8'h00;
        else if (wr && (idx == `IDX_DUTY_EXT || idx == `IDX_DUTY_MIR))
            duty_buf_q <= PWDATA[`EXT_HI:`EXT_LO];
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            period_buf_q <= 8'h00;
        else if (wr && (idx == `IDX_PERIOD_EXT || idx == `IDX_PERIOD_MIR))
            period_buf_q <= PWDATA[`EXT_HI:`EXT_LO];
    end

    // Coarse halves: combined word only through the mirror
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            period_crs_q <= 16'h0000;
        else if (wr && idx == `IDX_PERIOD_MIR)
            period_crs_q <= PWDATA[`CRS_HI:`CRS_LO];
        else if (wr && idx == `IDX_PERIOD_CRS)
            period_crs_q <= PWDATA[15:0];
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            duty_crs_q <= 16'h0000;
        else if (wr && idx == `IDX_DUTY_MIR)
            duty_crs_q <= PWDATA[`CRS_HI:`CRS_LO];
        else if (wr && idx == `IDX_DUTY_CRS)
            duty_crs_q <= PWDATA[15:0];
    end

    assign PERIOD_COARSE = period_crs_q;
    assign DUTY_COARSE = duty_crs_q;

    // Shadowed copies move at period start only
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            duty_act_q <= 8'h00;
            period_act_q <= 8'h00;
        end
        else if (!cfg_q.shadow_en || TB_PRD_START)
        begin
            duty_act_q <= duty_buf_q;
            period_act_q <= period_buf_q;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            rdata_q <= 32'h0000_0000;
        else if (rd_setup)
        begin
            unique case (idx)
                `IDX_PHASE_EXT: rdata_q <= {16'h0000, phase_q, 8'h00};
                `IDX_PERIOD_EXT: rdata_q <= {16'h0000, period_buf_q, 8'h00};
                `IDX_DUTY_EXT: rdata_q <= {16'h0000, duty_buf_q, 8'h00};
                `IDX_CONFIG: rdata_q <= {24'h00_0000, cfg_q};
                `IDX_STEPS: rdata_q <= {24'h00_0000, steps_q};
                `IDX_STATUS: rdata_q <= {23'h00_0000, blank, tap_q};
                `IDX_PERIOD_CRS: rdata_q <= {16'h0000, period_crs_q};
                `IDX_DUTY_CRS: rdata_q <= {16'h0000, duty_crs_q};
                // Mirrors and unmapped words read as zero
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Blanking after period start when fine period is off
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            blank_cnt_q <= 2'h0;
        else if (TB_PRD_START)
            blank_cnt_q <= `BLANK_CYCLES - 2'h1;
        else if (blank_cnt_q != 2'h0)
            blank_cnt_q <= blank_cnt_q - 2'h1;
    end

    assign blank = (TB_PRD_START || blank_cnt_q != 2'h0) && !cfg_q.prd_en;

    // Tracks the pin through reset so release shows no false edge
    always_ff @(posedge SYS_CLK)
    begin
        a_q <= PWM_A_RAW;
    end

    assign rise = PWM_A_RAW & ~a_q;
    assign fall = ~PWM_A_RAW & a_q;

    always_comb
    begin
        unique case (cfg_q.edge_mode)
            fine_edge_pkg::EM_RISE: sel_edge = rise;
            fine_edge_pkg::EM_FALL: sel_edge = fall;
            fine_edge_pkg::EM_BOTH: sel_edge = rise | fall;
            fine_edge_pkg::EM_OFF: sel_edge = 1'b0;
        endcase
    end

    // Period edge takes period steps; other edges keep duty or phase
    always_comb
    begin
        if (cfg_q.prd_en && TB_PRD_START)
            steps_now = conv(period_act_q, steps_q, cfg_q.auto_conv);
        else if (cfg_q.ctl_phase)
            steps_now = phase_q;
        else
            steps_now = conv(duty_act_q, steps_q, cfg_q.auto_conv);
    end

    // Tap holds until the next selected edge on the A path; edge mode off clears it to zero
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            tap_q <= 8'h00;
        else if (cfg_q.edge_mode == fine_edge_pkg::EM_OFF)
            tap_q <= 8'h00;
        else if (sel_edge)
            tap_q <= blank ? 8'h00 : steps_now;
    end

    assign DELAY_TAP = tap_q;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
        end
        else
        begin
            out_a_q <= cfg_q.swap ? PWM_B_RAW : PWM_A_RAW;
            if (cfg_q.swap)
                out_b_q <= PWM_A_RAW;
            else
                out_b_q <= cfg_q.inv_b ? ~PWM_A_RAW : PWM_B_RAW;
        end
    end

    assign PWM_OUT_A = out_a_q;
    assign PWM_OUT_B = out_b_q;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_start_nofine;
        TB_PRD_START && !cfg_q.prd_en && !(wr && idx == `IDX_CONFIG);
    endsequence

    // Fine period enable lifts blanking, so it is allowed mid-window
    sequence s_blank3;
        (blank || cfg_q.prd_en) [*3];
    endsequence

    sequence s_quiet3;
        (!TB_PRD_START && !cfg_q.prd_en) [*3];
    endsequence

    a_blank_three: assert property (s_start_nofine |-> s_blank3)
        else $error("blank window short");

    a_blank_span: assert property (s_start_nofine ##1 s_quiet3
        |-> $past(blank, 3) && $past(blank, 2) && $past(blank, 1) && !blank)
        else $error("blank not three cycles");

    a_tap_steps: assert property (sel_edge && !blank
        && cfg_q.edge_mode != fine_edge_pkg::EM_OFF |=> DELAY_TAP == $past(steps_now))
        else $error("tap not step count");

    a_swap_route: assert property (cfg_q.swap
        |=> PWM_OUT_A == $past(PWM_B_RAW) && PWM_OUT_B == $past(PWM_A_RAW))
        else $error("swap routing wrong");

    a_invert_b: assert property (!cfg_q.swap && cfg_q.inv_b
        |=> PWM_OUT_B == !$past(PWM_A_RAW))
        else $error("B not inverted A");

    a_manual_steps: assert property (!cfg_q.auto_conv && !cfg_q.ctl_phase
        && !TB_PRD_START |-> steps_now == duty_act_q)
        else $error("manual steps not raw");

    a_phase_steps: assert property (cfg_q.ctl_phase && !TB_PRD_START
        |-> steps_now == phase_q)
        else $error("phase source wrong");

    a_mirror_write: assert property (wr && idx == `IDX_PERIOD_MIR
        |=> period_crs_q == $past(PWDATA[31:16]) && period_buf_q == $past(PWDATA[15:8]))
        else $error("mirror write lost");

    a_primary_no_crs: assert property (wr && idx == `IDX_PERIOD_EXT
        |=> $stable(period_crs_q))
        else $error("primary wrote coarse");

    a_mirror_read: assert property (rd_setup
        && (idx == `IDX_DUTY_MIR || idx == `IDX_PERIOD_MIR) |=> PRDATA == 32'h0000_0000)
        else $error("mirror read nonzero");

    a_phase_direct: assert property (wr && idx == `IDX_PHASE_EXT
        |=> phase_q == $past(PWDATA[15:8]))
        else $error("phase not direct");

    a_shadow_hold: assert property (cfg_q.shadow_en && !TB_PRD_START
        |=> duty_act_q == $past(duty_act_q) && period_act_q == $past(period_act_q))
        else $error("shadow leaked");

    a_tap_off: assert property (cfg_q.edge_mode == fine_edge_pkg::EM_OFF
        |=> DELAY_TAP == 8'h00)
        else $error("tap active while off");

    a_tap_blank: assert property (sel_edge && blank
        && cfg_q.edge_mode != fine_edge_pkg::EM_OFF |=> DELAY_TAP == 8'h00)
        else $error("tap during blank");

endmodule

/* testbench/pwm_time_base_model.sv */
// Behavioural time base and compare logic feeding the fine edge block
`timescale 1ns/1ns
module pwm_time_base_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] period,
    input wire logic [15:0] duty,
    output logic start,
    output logic a_raw,
    output logic b_raw
);
    logic [15:0] cnt_q;

    // Up-count, wraps after period; period 0 keeps start asserted
    always_ff @(posedge clk)
    begin
        if (!rst_n || cnt_q >= period)
            cnt_q <= 16'h0000;
        else
            cnt_q <= cnt_q + 16'h0001;
    end

    assign start = rst_n && (cnt_q == 16'h0000);
    // A falls at the period start, so a falling edge lands in the blank window
    assign a_raw = (cnt_q >= duty);
    // Unrelated to A so swap and invert are told apart
    assign b_raw = cnt_q[1];
endmodule

/* testbench/fine_edge_pwm_test.sv */
// Self-checking bench for the fine edge PWM extension
`timescale 1ns/1ns
`include "fine_edge_defines.svh"
module fine_edge_pwm_test;
    logic SYS_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, TB_PRD_START, PWM_A_RAW, PWM_B_RAW, PWM_OUT_A, PWM_OUT_B;
    logic [7:0] DELAY_TAP;
    logic [15:0] PERIOD_COARSE, DUTY_COARSE;
    logic [31:0] rd;
    logic er;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;

    always #5 SYS_CLK = ~SYS_CLK;

    fine_edge_pwm dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .TB_PRD_START(TB_PRD_START), .PWM_A_RAW(PWM_A_RAW),
        .PWM_B_RAW(PWM_B_RAW), .PWM_OUT_A(PWM_OUT_A), .PWM_OUT_B(PWM_OUT_B),
        .DELAY_TAP(DELAY_TAP), .PERIOD_COARSE(PERIOD_COARSE), .DUTY_COARSE(DUTY_COARSE));

    pwm_time_base_model time_base_regs (.clk(SYS_CLK), .rst_n(RST_N), .period(PERIOD_COARSE),
        .duty(DUTY_COARSE), .start(TB_PRD_START), .a_raw(PWM_A_RAW), .b_raw(PWM_B_RAW));

    task end_sim;
        if (failures == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; ends past the next falling edge so registered outputs settle
    task apb(input logic wr, input logic [5:0] idx, input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= {idx, 2'b00};
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        @(posedge SYS_CLK);
        while (PREADY !== 1'b1)
            @(posedge SYS_CLK);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(negedge SYS_CLK);
    endtask

    // Two full periods let shadow copies load and a selected edge pass
    task cfg_tap(input logic [7:0] cfg, input logic [7:0] exp);
        apb(1'b1, `IDX_CONFIG, {24'h0, cfg});
        repeat (50) @(posedge SYS_CLK);
        @(negedge SYS_CLK);
        chk({24'h0, DELAY_TAP}, {24'h0, exp}, "delay tap");
    endtask

    task pins(input logic [7:0] cfg, input logic sw, input logic inv);
        logic a;
        logic b;
        apb(1'b1, `IDX_CONFIG, {24'h0, cfg});
        repeat (30)
        begin
            @(negedge SYS_CLK);
            a = PWM_A_RAW;
            b = PWM_B_RAW;
            @(negedge SYS_CLK);
            chk({31'h0, PWM_OUT_A}, {31'h0, sw ? b : a}, "pin a");
            chk({31'h0, PWM_OUT_B}, {31'h0, sw ? a : (inv ? ~a : b)}, "pin b");
        end
    endtask

    always @(posedge SYS_CLK)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            $display("[ERR] %0t timeout", $time);
            end_sim;
        end
    end

    initial
    begin
        repeat (10) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        @(negedge SYS_CLK);
        chk({24'h0, DELAY_TAP}, 32'h0, "tap after reset");
        apb(1'b0, `IDX_CONFIG, 32'h0);
        chk(rd, 32'h0, "config reset");
        apb(1'b1, `IDX_PERIOD_MIR, 32'h0014_0000);
        chk({16'h0, PERIOD_COARSE}, 32'h14, "period coarse");
        apb(1'b0, `IDX_PERIOD_MIR, 32'h0);
        chk(rd, 32'h0, "mirror read");
        apb(1'b1, `IDX_DUTY_MIR, 32'h0008_4000);
        chk({16'h0, DUTY_COARSE}, 32'h8, "duty coarse");
        apb(1'b1, `IDX_DUTY_EXT, 32'hffff_25b3);
        chk({16'h0, DUTY_COARSE}, 32'h8, "primary keeps coarse");
        apb(1'b1, `IDX_STEPS, 32'h80);
        cfg_tap(8'h01, 8'h25);
        cfg_tap(8'h00, 8'h00);
        cfg_tap(8'h41, 8'h13);
        apb(1'b1, `IDX_STEPS, 32'h40);
        cfg_tap(8'h41, 8'h09);
        cfg_tap(8'h02, 8'h00);
        apb(1'b1, `IDX_PHASE_EXT, 32'h0000_0700);
        cfg_tap(8'h05, 8'h07);
        apb(1'b1, `IDX_PHASE_EXT, 32'h0000_1100);
        cfg_tap(8'h0d, 8'h11);
        apb(1'b1, `IDX_DUTY_EXT, 32'h0000_33ff);
        cfg_tap(8'h09, 8'h33);
        apb(1'b1, `IDX_PERIOD_EXT, 32'hffff_60a5);
        chk({16'h0, PERIOD_COARSE}, 32'h14, "primary period keeps coarse");
        cfg_tap(8'hc2, 8'h18);
        apb(1'b0, `IDX_STATUS, 32'h0);
        chk(rd, 32'h18, "status no blank");
        cfg_tap(8'hc1, 8'h0d);
        pins(8'h01, 1'b0, 1'b0);
        pins(8'h21, 1'b0, 1'b1);
        pins(8'h11, 1'b1, 1'b0);
        pins(8'h31, 1'b1, 1'b0);
        apb(1'b0, `IDX_CONFIG, 32'h0);
        chk(rd, 32'h31, "config readback");
        apb(1'b0, 6'h3f, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        @(posedge SYS_CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        apb(1'b0, `IDX_CONFIG, 32'h0);
        chk(rd, 32'h0, "config second reset");
        chk({16'h0, PERIOD_COARSE}, 32'h0, "coarse second reset");
        end_sim;
    end
endmodule
